// ---- psc_cfg.svh ----
// Timing counts, register offsets and field positions of the loader
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

`define PSC_CLK_NS       25
`define PSC_CLK_HZ       40000000
`define PSC_POR_NS       100000000
`define PSC_POR_CYC      (`PSC_POR_NS / `PSC_CLK_NS)
`define PSC_OSC_HZ       10000000
`define PSC_OSC_DIV      (`PSC_CLK_HZ / `PSC_OSC_HZ)
`define PSC_INIT_CYC     299
`define PSC_EXT_MAX_MHZ  100
`define PSC_ERR_NS       40000
`define PSC_ERR_CYC      (`PSC_ERR_NS / `PSC_CLK_NS)
`define PSC_NCFG_NS      2000
`define PSC_NCFG_CYC     ((`PSC_NCFG_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_SCLK_NS      200
`define PSC_SCLK_HALF    (`PSC_SCLK_NS / 2 / `PSC_CLK_NS)
`define PSC_EXT_HALF     2
`define PSC_DONE_TO_CYC  4096
`define PSC_CD2UM_CYC    4096
`define PSC_FILE_BITS    64
`define PSC_SYNC_PAT     7'h2A

`define PSC_REG_CTRL     8'h00
`define PSC_REG_STAT     8'h04
`define PSC_REG_DATA     8'h08
`define PSC_REG_LEN      8'h0C

`define PSC_CTRL_START   0
`define PSC_CTRL_FIN     1
`define PSC_CTRL_EXT     2
`define PSC_CTRL_AUTO    3
`define PSC_STAT_USER    3
`define PSC_STAT_ERR     4
`define PSC_STAT_RETRY   5
`define PSC_STAT_FULL    6
`define PSC_STAT_READY   7
`define PSC_STAT_DONE    8

`endif

// ---- psc_pkg.sv ----
// Types shared by both ends of the loader
package psc_pkg;

   typedef enum logic [2:0] {
      DEV_POR   = 3'b000,
      DEV_RESET = 3'b001,
      DEV_LOAD  = 3'b010,
      DEV_INIT  = 3'b011,
      DEV_USER  = 3'b100,
      DEV_ERROR = 3'b101
   } psc_dev_st_t;

   typedef enum logic [2:0] {
      H_IDLE     = 3'b000,
      H_NCFG     = 3'b001,
      H_WAITRDY  = 3'b010,
      H_SEND     = 3'b011,
      H_WAITDONE = 3'b100,
      H_WAITUSER = 3'b101,
      H_USER     = 3'b110,
      H_ERROR    = 3'b111
   } psc_host_st_t;

endpackage

// ---- psc_link_if.sv ----
// Link between loading host and configured device, with pull-ups
`timescale 1ns/1ps
interface psc_link_if;
   logic reconfigure_request_n;
   logic serial_bit_clock;
   logic serial_bit_in;
   logic external_init_clock;
   logic ready_o;
   logic ready_oe;
   logic done_o;
   logic done_oe;
   logic fin_o;
   logic fin_oe;
   logic ready_or_error_n;
   logic load_complete;
   logic startup_finished;

   // Open-drain lines float high unless pulled
   assign ready_or_error_n = ready_oe ? ready_o : 1'b1;
   assign load_complete    = done_oe  ? done_o  : 1'b1;
   assign startup_finished = fin_oe   ? fin_o   : 1'b1;

   modport dev_mp (
      input  reconfigure_request_n,
      input  serial_bit_clock,
      input  serial_bit_in,
      input  external_init_clock,
      input  ready_or_error_n,
      output ready_o,
      output ready_oe,
      output done_o,
      output done_oe,
      output fin_o,
      output fin_oe
   );

   modport host_mp (
      output reconfigure_request_n,
      output serial_bit_clock,
      output serial_bit_in,
      output external_init_clock,
      input  ready_or_error_n,
      input  load_complete,
      input  startup_finished
   );
endinterface // psc_link_if

// ---- psc_dev.sv ----
// Configured device end: reset, serial load, initialization, user mode
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_dev
   import psc_pkg::*;
#(
   parameter int unsigned POR_CYC   = `PSC_POR_CYC,
   parameter int unsigned FILE_BITS = `PSC_FILE_BITS,
   parameter int unsigned INIT_CYC  = `PSC_INIT_CYC,
   parameter int unsigned ERR_CYC   = `PSC_ERR_CYC
) (
   input  wire logic   pclk,
   input  wire logic   presetn,
   psc_link_if.dev_mp  lnk,
   input  wire logic   auto_restart_en,
   input  wire logic   ext_clk_en,
   output logic        user_io_en,
   output logic        load_error
);

   function automatic logic rise(input logic now_v, input logic old_v);
      return now_v & ~old_v;
   endfunction

   psc_dev_st_t state_r;
   logic [1:0]  rq_sy;
   logic [1:0]  rd_sy;
   logic [1:0]  sd_sy;
   logic [2:0]  sc_sy;
   logic [2:0]  ec_sy;
   logic [3:0]  osc_r;
   logic [31:0] cnt_r;
   logic [31:0] bits_r;
   logic [7:0]  shift_r;
   logic        ready_oe_r;
   logic        done_oe_r;
   logic        fin_oe_r;
   logic        sclk_rise;
   logic        osc_tick;
   logic        init_tick;
   logic [7:0]  new_byte;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rq_sy <= 2'h0;
         rd_sy <= 2'h0;
         sd_sy <= 2'h0;
         sc_sy <= 3'h0;
         ec_sy <= 3'h0;
      end else begin
         rq_sy <= {rq_sy[0], lnk.reconfigure_request_n};
         rd_sy <= {rd_sy[0], lnk.ready_or_error_n};
         sd_sy <= {sd_sy[0], lnk.serial_bit_in};
         sc_sy <= {sc_sy[1:0], lnk.serial_bit_clock};
         ec_sy <= {ec_sy[1:0], lnk.external_init_clock};
      end
   end

   assign sclk_rise = rise(sc_sy[1], sc_sy[2]);
   assign new_byte  = {sd_sy[1], shift_r[7:1]};

   ////////////////////////////////////////////////////////////////////////
   // Internal initialization oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_r <= 4'h0;
      end else if (osc_tick) begin
         osc_r <= 4'h0;
      end else begin
         osc_r <= osc_r + 4'h1;
      end
   end

   assign osc_tick  = (osc_r == 4'(`PSC_OSC_DIV - 1));
   assign init_tick = ext_clk_en ? rise(ec_sy[1], ec_sy[2]) : osc_tick;

   ////////////////////////////////////////////////////////////////////////
   // Configuration sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= DEV_POR;
         cnt_r      <= 32'h0;
         bits_r     <= 32'h0;
         shift_r    <= 8'h00;
         ready_oe_r <= 1'b1;
         done_oe_r  <= 1'b1;
         fin_oe_r   <= 1'b0;
         user_io_en <= 1'b0;
         load_error <= 1'b0;
      end else if (state_r != DEV_POR && !rq_sy[1]) begin
         state_r    <= DEV_RESET;
         ready_oe_r <= 1'b1;
         done_oe_r  <= 1'b1;
         fin_oe_r   <= 1'b0;
         user_io_en <= 1'b0;
         load_error <= 1'b0;
      end else begin
         unique case (state_r)
            DEV_POR: begin
               ready_oe_r <= 1'b1;
               cnt_r      <= cnt_r + 32'h1;
               if (cnt_r == POR_CYC - 1) begin
                  state_r <= DEV_RESET;
                  cnt_r   <= 32'h0;
               end
            end
            DEV_RESET: begin
               ready_oe_r <= 1'b0;
               done_oe_r  <= 1'b1;
               bits_r     <= 32'h0;
               if (!ready_oe_r && rd_sy[1]) begin
                  state_r <= DEV_LOAD;
               end
            end
            DEV_LOAD: begin
               if (!rd_sy[1]) begin
                  state_r <= DEV_RESET;
               end else if (sclk_rise) begin
                  shift_r <= new_byte;
                  bits_r  <= bits_r + 32'h1;
                  if (bits_r == 32'h7 && new_byte[7:1] != `PSC_SYNC_PAT) begin
                     state_r    <= DEV_ERROR;
                     ready_oe_r <= 1'b1;
                     load_error <= 1'b1;
                     cnt_r      <= 32'h0;
                  end else begin
                     if (bits_r == 32'h7) begin
                        fin_oe_r <= new_byte[0];
                     end
                     if (bits_r == FILE_BITS - 1) begin
                        state_r   <= DEV_INIT;
                        done_oe_r <= 1'b0;
                        cnt_r     <= 32'h0;
                     end
                  end
               end
            end
            DEV_INIT: begin
               // Serial clock edges are not looked at here
               if (init_tick) begin
                  cnt_r <= cnt_r + 32'h1;
                  if (cnt_r == INIT_CYC - 1) begin
                     state_r    <= DEV_USER;
                     fin_oe_r   <= 1'b0;
                     user_io_en <= 1'b1;
                  end
               end
            end
            DEV_USER: begin
               user_io_en <= 1'b1;
            end
            DEV_ERROR: begin
               ready_oe_r <= 1'b1;
               done_oe_r  <= 1'b1;
               fin_oe_r   <= 1'b0;
               if (auto_restart_en) begin
                  cnt_r <= cnt_r + 32'h1;
                  if (cnt_r == ERR_CYC - 1) begin
                     state_r    <= DEV_RESET;
                     ready_oe_r <= 1'b0;
                  end
               end
            end
            default: begin
               state_r <= DEV_RESET;
            end
         endcase
      end
   end

   // Open-drain pins only ever pull low
   assign lnk.ready_o  = 1'b0;
   assign lnk.done_o   = 1'b0;
   assign lnk.fin_o    = 1'b0;
   assign lnk.ready_oe = ready_oe_r;
   assign lnk.done_oe  = done_oe_r;
   assign lnk.fin_oe   = fin_oe_r;

endmodule // psc_dev

// ---- psc_host.sv ----
// Loading host end: APB register slave driving the serial load
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_host
   import psc_pkg::*;
#(
   parameter int unsigned NCFG_CYC  = `PSC_NCFG_CYC,
   parameter int unsigned SCLK_HALF = `PSC_SCLK_HALF,
   parameter int unsigned EXT_HALF  = `PSC_EXT_HALF,
   parameter int unsigned DONE_TO   = `PSC_DONE_TO_CYC,
   parameter int unsigned CD2UM_CYC = `PSC_CD2UM_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   psc_link_if.host_mp      lnk
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   psc_host_st_t state_r;
   logic [1:0]  rd_sy;
   logic [1:0]  dn_sy;
   logic [2:0]  fn_sy;
   logic        ctrl_fin_r;
   logic        ctrl_ext_r;
   logic        ctrl_auto_r;
   logic [23:0] len_r;
   logic [7:0]  data_r;
   logic        full_r;
   logic        err_r;
   logic        retry_r;
   logic [31:0] cnt_r;
   logic [15:0] hcnt_r;
   logic [2:0]  bit_r;
   logic [23:0] sent_r;
   logic        rq_r;
   logic        sclk_r;
   logic        sd_r;
   logic        ext_r;
   logic [15:0] ecnt_r;
   logic        wr;
   logic        start;
   logic        loading;
   logic        stall;
   logic        mapped;
   logic        fin_rise;
   logic [31:0] rd_val;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_sy <= 2'h0;
         dn_sy <= 2'h0;
         fn_sy <= 3'h7;
      end else begin
         rd_sy <= {rd_sy[0], lnk.ready_or_error_n};
         dn_sy <= {dn_sy[0], lnk.load_complete};
         fn_sy <= {fn_sy[1:0], lnk.startup_finished};
      end
   end

   assign fin_rise = fn_sy[1] & ~fn_sy[2];

   ////////////////////////////////////////////////////////////////////////
   // APB slave
   assign wr      = psel & penable & pready & pwrite;
   assign start   = wr & hit(paddr, `PSC_REG_CTRL) & pwdata[`PSC_CTRL_START];
   assign loading = (state_r == H_WAITRDY) || (state_r == H_SEND);
   assign stall   = pwrite & hit(paddr, `PSC_REG_DATA) & full_r & loading;
   assign mapped  = hit(paddr, `PSC_REG_CTRL) | hit(paddr, `PSC_REG_STAT) |
                    hit(paddr, `PSC_REG_DATA) | hit(paddr, `PSC_REG_LEN);

   always_comb begin
      rd_val = 32'h0;
      if (hit(paddr, `PSC_REG_CTRL)) begin
         rd_val[`PSC_CTRL_FIN]  = ctrl_fin_r;
         rd_val[`PSC_CTRL_EXT]  = ctrl_ext_r;
         rd_val[`PSC_CTRL_AUTO] = ctrl_auto_r;
      end else if (hit(paddr, `PSC_REG_STAT)) begin
         rd_val[2:0]             = state_r;
         rd_val[`PSC_STAT_USER]  = (state_r == H_USER);
         rd_val[`PSC_STAT_ERR]   = err_r;
         rd_val[`PSC_STAT_RETRY] = retry_r;
         rd_val[`PSC_STAT_FULL]  = full_r;
         rd_val[`PSC_STAT_READY] = rd_sy[1];
         rd_val[`PSC_STAT_DONE]  = dn_sy[1];
      end else if (hit(paddr, `PSC_REG_DATA)) begin
         rd_val[7:0] = data_r;
      end else if (hit(paddr, `PSC_REG_LEN)) begin
         rd_val[23:0] = len_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (psel && penable && !pready && !stall) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= rd_val;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_fin_r  <= 1'b0;
         ctrl_ext_r  <= 1'b0;
         ctrl_auto_r <= 1'b0;
         len_r       <= 24'h0;
      end else if (wr && hit(paddr, `PSC_REG_CTRL)) begin
         ctrl_fin_r  <= pwdata[`PSC_CTRL_FIN];
         ctrl_ext_r  <= pwdata[`PSC_CTRL_EXT];
         ctrl_auto_r <= pwdata[`PSC_CTRL_AUTO];
      end else if (wr && hit(paddr, `PSC_REG_LEN)) begin
         len_r <= pwdata[23:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // User init clock, free running while enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_r  <= 1'b0;
         ecnt_r <= 16'h0;
      end else if (!ctrl_ext_r) begin
         ext_r  <= 1'b0;
         ecnt_r <= 16'h0;
      end else if (ecnt_r == 16'(EXT_HALF - 1)) begin
         ext_r  <= ~ext_r;
         ecnt_r <= 16'h0;
      end else begin
         ecnt_r <= ecnt_r + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Load sequence; load complete is only ever sampled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= H_IDLE;
         rq_r    <= 1'b0;
         sclk_r  <= 1'b0;
         sd_r    <= 1'b0;
         data_r  <= 8'h00;
         full_r  <= 1'b0;
         err_r   <= 1'b0;
         retry_r <= 1'b0;
         cnt_r   <= 32'h0;
         hcnt_r  <= 16'h0;
         bit_r   <= 3'h0;
         sent_r  <= 24'h0;
      end else begin
         if (wr && hit(paddr, `PSC_REG_STAT)) begin
            err_r   <= err_r & ~pwdata[`PSC_STAT_ERR];
            retry_r <= retry_r & ~pwdata[`PSC_STAT_RETRY];
         end
         if (wr && hit(paddr, `PSC_REG_DATA) && !full_r) begin
            data_r <= pwdata[7:0];
            full_r <= 1'b1;
         end
         if (start) begin
            state_r <= H_NCFG;
            rq_r    <= 1'b0;
            cnt_r   <= 32'h0;
            sent_r  <= 24'h0;
            full_r  <= 1'b0;
            sclk_r  <= 1'b0;
         end else begin
            unique case (state_r)
               H_IDLE: begin
               end
               H_NCFG: begin
                  cnt_r <= cnt_r + 32'h1;
                  if (cnt_r == NCFG_CYC - 1) begin
                     rq_r    <= 1'b1;
                     state_r <= H_WAITRDY;
                  end
               end
               H_WAITRDY: begin
                  hcnt_r <= 16'h0;
                  bit_r  <= 3'h0;
                  if (rd_sy[1]) begin
                     state_r <= H_SEND;
                  end
               end
               H_SEND: begin
                  if (!rd_sy[1]) begin
                     err_r   <= 1'b1;
                     sclk_r  <= 1'b0;
                     state_r <= H_ERROR;
                  end else if (dn_sy[1]) begin
                     sclk_r  <= 1'b0;
                     sd_r    <= 1'b0;
                     cnt_r   <= 32'h0;
                     state_r <= H_WAITUSER;
                  end else if (sclk_r) begin
                     hcnt_r <= hcnt_r + 16'h1;
                     if (hcnt_r == 16'(SCLK_HALF - 1)) begin
                        sclk_r <= 1'b0;
                        hcnt_r <= 16'h0;
                        bit_r  <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                           full_r <= 1'b0;
                           sent_r <= sent_r + 24'h1;
                        end
                     end
                  end else if (sent_r == len_r) begin
                     cnt_r   <= 32'h0;
                     state_r <= H_WAITDONE;
                  end else if (full_r) begin
                     sd_r   <= data_r[bit_r];
                     hcnt_r <= hcnt_r + 16'h1;
                     if (hcnt_r == 16'(SCLK_HALF - 1)) begin
                        sclk_r <= 1'b1;
                        hcnt_r <= 16'h0;
                     end
                  end
                  // No data: clock stays low
               end
               H_WAITDONE: begin
                  cnt_r <= cnt_r + 32'h1;
                  if (dn_sy[1]) begin
                     cnt_r   <= 32'h0;
                     sd_r    <= 1'b0;
                     state_r <= H_WAITUSER;
                  end else if (!rd_sy[1]) begin
                     err_r   <= 1'b1;
                     state_r <= H_ERROR;
                  end else if (cnt_r == DONE_TO - 1) begin
                     retry_r <= 1'b1;
                     rq_r    <= 1'b0;
                     cnt_r   <= 32'h0;
                     sent_r  <= 24'h0;
                     state_r <= H_NCFG;
                  end
               end
               H_WAITUSER: begin
                  cnt_r <= cnt_r + 32'h1;
                  if (!rd_sy[1]) begin
                     err_r   <= 1'b1;
                     state_r <= H_ERROR;
                  end else if (ctrl_fin_r && fin_rise) begin
                     state_r <= H_USER;
                  end else if (ctrl_fin_r && cnt_r == DONE_TO - 1) begin
                     retry_r <= 1'b1;
                     rq_r    <= 1'b0;
                     cnt_r   <= 32'h0;
                     sent_r  <= 24'h0;
                     state_r <= H_NCFG;
                  end else if (!ctrl_fin_r && cnt_r == CD2UM_CYC - 1) begin
                     state_r <= H_USER;
                  end
               end
               H_USER: begin
                  sclk_r <= 1'b0;
                  sd_r   <= 1'b0;
               end
               H_ERROR: begin
                  sclk_r <= 1'b0;
                  if (ctrl_auto_r && rd_sy[1]) begin
                     sent_r  <= 24'h0;
                     full_r  <= 1'b0;
                     state_r <= H_WAITRDY;
                  end
                  // Otherwise software restarts with a pulse
               end
            endcase
         end
      end
   end

   assign lnk.reconfigure_request_n = rq_r;
   assign lnk.serial_bit_clock      = sclk_r;
   assign lnk.serial_bit_in         = sd_r;
   assign lnk.external_init_clock   = ext_r;

endmodule // psc_host

// ---- psc_chk_assertions.sv ----
// Link checker for the passive serial loader
`timescale 1ns/1ps
module psc_chk_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reconfigure_request_n,
   input wire logic serial_bit_clock,
   input wire logic serial_bit_in,
   input wire logic ready_or_error_n,
   input wire logic load_complete,
   input wire logic startup_finished
);
   logic [15:0] low_cnt_r;
   logic [15:0] done_cnt_r;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Cycles the request line has been low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_cnt_r <= 16'h0000;
      else if (reconfigure_request_n) low_cnt_r <= 16'h0000;
      else if (low_cnt_r != 16'hFFFF) low_cnt_r <= low_cnt_r + 16'h0001;
   end

   // Cycles since load complete rose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) done_cnt_r <= 16'h0000;
      else if (!load_complete) done_cnt_r <= 16'h0000;
      else if (done_cnt_r != 16'hFFFF) done_cnt_r <= done_cnt_r + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////
   chk_cfg_reset: assert property (!reconfigure_request_n [*4] |->
      !ready_or_error_n && !load_complete) else $error("not in reset");
   chk_ready_rel: assert property ($rose(reconfigure_request_n) |->
      ##[1:6] ready_or_error_n) else $error("ready not released");
   chk_low_len: assert property ($rose(reconfigure_request_n) |->
      low_cnt_r >= 16'h0050) else $error("request pulse short");
   chk_done_ok: assert property ($rose(load_complete) |->
      ready_or_error_n) else $error("done during error");
   chk_sample_edge: assert property ($changed(serial_bit_in) |->
      !serial_bit_clock) else $error("data moved with clock high");
   chk_sclk_quiet: assert property (load_complete &&
      $past(load_complete, 8) |-> $stable(serial_bit_clock))
      else $error("serial clock after load");
   chk_init_len: assert property ($rose(startup_finished) &&
      load_complete |-> done_cnt_r >= 16'h04A6)
      else $error("init too short");
   chk_fin_user: assert property (load_complete &&
      done_cnt_r == 16'h0514 |-> startup_finished)
      else $error("finished not released");
endmodule // psc_chk_assertions

// ---- tb_passive_serial_config_load.sv ----
// Bench joining host and device ends of the serial loader
`timescale 1ns/1ps
`include "psc_cfg.svh"
module tb_passive_serial_config_load;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        auto_restart_en = 1'b0;
   logic        ext_clk_en = 1'b0;
   logic        user_io_en;
   logic        load_error;
   logic [31:0] rd;
   logic        er;
   int          bad_count = 0;
   int          n_checks = 0;

   psc_link_if lnk ();
   psc_dev #(.POR_CYC(20)) i_psc_dev (.pclk(pclk), .presetn(presetn),
      .lnk(lnk), .auto_restart_en(auto_restart_en),
      .ext_clk_en(ext_clk_en), .user_io_en(user_io_en),
      .load_error(load_error));
   psc_host #(.DONE_TO(1500), .CD2UM_CYC(1300)) i_psc_host (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lnk(lnk));
   psc_chk_assertions i_psc_chk_assertions (.pclk(pclk),
      .presetn(presetn),
      .reconfigure_request_n(lnk.reconfigure_request_n),
      .serial_bit_clock(lnk.serial_bit_clock),
      .serial_bit_in(lnk.serial_bit_in),
      .ready_or_error_n(lnk.ready_or_error_n),
      .load_complete(lnk.load_complete),
      .startup_finished(lnk.startup_finished));

   always #12.5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task conclude;
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read status until state field top bits match
   task automatic poll(input logic [1:0] st);
      int i;
      i = 0;
      do begin
         apb(1'b0, `PSC_REG_STAT, 32'h0);
         i++;
      end while (rd[2:1] !== st && i < 3000);
   endtask

   task automatic load(input logic [7:0] b0, input logic [3:0] ctl,
                       input int nb);
      int i;
      auto_restart_en <= ctl[3];
      ext_clk_en <= ctl[2];
      apb(1'b1, `PSC_REG_LEN, 32'h8);
      apb(1'b1, `PSC_REG_CTRL, {28'h0, ctl} | 32'h1);
      apb(1'b0, `PSC_REG_CTRL, 32'h0);
      chk(rd, {28'h0, ctl[3:1], 1'b0});
      chk(er, 1'b0);
      poll(2'b01);
      chk(user_io_en, 1'b0);
      chk(lnk.load_complete, 1'b0);
      apb(1'b1, `PSC_REG_DATA, {24'h0, b0});
      for (i = 1; i < nb; i++) begin
         apb(1'b1, `PSC_REG_DATA, {29'h0, i[2:0]});
      end
   endtask

   task automatic t_good(input logic [7:0] b0, input logic [3:0] ctl);
      load(b0, ctl, 8);
      poll(2'b11);
      chk(rd[3], 1'b1);
      chk(user_io_en, 1'b1);
      chk(load_error, 1'b0);
      chk(lnk.load_complete, 1'b1);
      chk(lnk.startup_finished, 1'b1);
   endtask

   task automatic t_err;
      int n;
      load(8'h00, 4'b1000, 1);
      n = 0;
      while (load_error !== 1'b1 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk(load_error, 1'b1);
      chk(lnk.ready_or_error_n, 1'b0);
      n = 0;
      while (lnk.ready_or_error_n !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk(n > 1580 && n <= 1600, 1'b1);
      apb(1'b0, `PSC_REG_STAT, 32'h0);
      chk(rd[`PSC_STAT_ERR], 1'b1);
   endtask

   task automatic t_unmap;
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, `PSC_REG_LEN, 32'h0);
      chk(rd, 32'h8);
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(lnk.ready_or_error_n, 1'b0);
      chk(user_io_en, 1'b0);
      repeat (30) @(posedge pclk);
      t_good(8'h55, 4'b0010);
      t_good(8'h54, 4'b0100);
      t_err;
      t_good(8'h55, 4'b0000);
      t_unmap;
      conclude;
   end

   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      conclude;
   end
endmodule // tb_passive_serial_config_load
